// >>> inc/pof_consts.svh
`ifndef POF_CONSTS_SVH
`define POF_CONSTS_SVH
// Purpose: Offsets, field positions, reset values and timing counts of the output formatter.
// Assumes: Register addresses are 8 bits wide and registers are 8 bits wide.
// Notes: Pixel fields are 7 bits per colour.

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define POF_REG_FMT 8'h15
`define POF_REG_HS 8'h16
`define POF_REG_MON 8'h17

// -----------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------
`define POF_FMT_DUAL 7
`define POF_FMT_PAR 6
`define POF_FMT_SWAP 5
`define POF_FMT_RST 8'h00
`define POF_HS_POL 7
`define POF_HS_WIDTH_HI 6
`define POF_HS_RST 8'h90
`define POF_MON_SOG 0
`define POF_MON_PHASE_LO 1
`define POF_MON_PHASE_HI 2
`define POF_MON_RST 8'h00

// -----------------------------------------------------------------
// Timing counts in core clock cycles, and FIFO depth in words
// -----------------------------------------------------------------
`define POF_PHASE_TAPS 4
`define POF_SYNC_DLY 3
`define POF_FIFO_DEPTH 32
`endif

// >>> inc/pof_pkg.sv
// Purpose: Types shared by the output formatter files.
// Assumes: Seven bits per colour sample.
// Notes: The word carries the start-of-line flag beside the pixel.
package pof_pkg;
   typedef struct packed {
      logic [6:0] r;
      logic [6:0] g;
      logic [6:0] b;
   } pof_pix_t;

   typedef struct packed {
      logic sol;
      pof_pix_t pix;
   } pof_word_t;

   typedef struct packed {
      pof_pix_t a;
      pof_pix_t b;
      logic b_oe;
      logic clk;
      logic hs;
   } pof_out_t;

   typedef enum logic [1:0] {
      POF_ST_FIRST = 2'b01,
      POF_ST_SECOND = 2'b10
   } pof_slot_t;
endpackage

// >>> verilog/pof_fifo.sv
// Purpose: Word FIFO in front of the formatter.
// Assumes: DEPTH is a power of two.
// Notes: Full and empty come from pointers with one extra wrap bit.
module pof_fifo #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Fill side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // Drain side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q, wr_d, rd_q, rd_d;
   logic push, pop;

   assign o_in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
   assign o_out_valid = wr_q != rd_q;
   assign o_out_data = mem[rd_q[AW-1:0]];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   always_comb begin
      wr_d = wr_q + (AW+1)'(push);
      rd_d = rd_q + (AW+1)'(pop);
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= i_in_data;
      end
   end
endmodule

// >>> verilog/pof_hs_gen.sv
// Purpose: Rebuilds the line sync pulse with programmed width and polarity.
// Assumes: Width counts output pixels; zero width gives no pulse.
// Notes: Output is registered so it lands in the same cycle as the data stage.
module pof_hs_gen #(
   parameter int WBITS = 7
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Control
   input wire logic i_start,
   input wire logic i_pix_en,
   input wire logic [WBITS-1:0] i_width,
   input wire logic i_pol,
   // Sync out
   output logic o_hs
);
   logic [WBITS-1:0] cnt_q, cnt_d;
   logic hs_q, hs_d;

   always_comb begin
      cnt_d = cnt_q;
      if (i_start) begin
         cnt_d = i_width;
      end else if (i_pix_en && cnt_q != '0) begin
         cnt_d = cnt_q - WBITS'(1);
      end
      hs_d = (cnt_d != '0) ? i_pol : ~i_pol;
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         cnt_q <= '0;
         hs_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         hs_q <= hs_d;
      end
   end

   assign o_hs = hs_q;
endmodule

// >>> verilog/pof_formatter.sv
// Purpose: Routes pixels to port pairs and drives output clock, line sync and sync monitor.
// Assumes: One pixel every two core cycles; core clock is the pixel sampling clock.
// Notes: A phase delay line moves data, clocks and line sync together.
// Functional notes
// - Single mode: data on first port, second high-impedance.
// - Dual mode alternates pixels between both ports.
// - Parallel: both ports update every second pixel.
// - Interleaved: ports update alternately, one per pixel.
// - First pixel after line sync to first port.
// - Swap bit reverses the dual routing.
// - Fixed latency from sample to output.
// - Phase shift moves data, clocks, sync together.
// - Complementary output clock pair from pixel clock.
// - Single mode: output clock at pixel rate.
// - Dual mode: clock and data at half rate.
// - Line sync stays aligned with clock and data.
// - Software sets line sync polarity and width.
// - Monitor selects slicer result or delayed sync.
// - Monitor gets no processing beyond slicing.
`include "pof_consts.svh"
module pof_formatter import pof_pkg::*; #(
   parameter int DEPTH = `POF_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Register port
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // Sampled pixels
   input wire logic i_pix_valid,
   input wire pof_word_t i_pix,
   output logic o_pix_ready,
   // Downstream hold
   input wire logic i_out_ready,
   // Sync pins
   input wire logic i_hsync,
   input wire logic i_green_embedded_sync,
   // Output ports
   output pof_pix_t o_port_a,
   output pof_pix_t o_port_b,
   output logic o_port_b_oe,
   output logic o_data_out_clock,
   output logic o_data_out_clock_n,
   output logic o_line_sync_out,
   output logic o_sync_slice_monitor_out
);
   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [7:0] fmt_q, fmt_d, hs_q, hs_d, mon_q, mon_d, rdata_d;
   logic dual, par, swap;
   logic [1:0] phase;

   always_comb begin
      fmt_d = fmt_q;
      hs_d = hs_q;
      mon_d = mon_q;
      if (i_reg_wr) begin
         unique case (i_reg_addr)
            `POF_REG_FMT: fmt_d = i_reg_wdata;
            `POF_REG_HS: hs_d = i_reg_wdata;
            `POF_REG_MON: mon_d = i_reg_wdata;
            default: ;
         endcase
      end
      unique case (i_reg_addr)
         `POF_REG_FMT: rdata_d = fmt_q;
         `POF_REG_HS: rdata_d = hs_q;
         `POF_REG_MON: rdata_d = mon_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         fmt_q <= `POF_FMT_RST;
         hs_q <= `POF_HS_RST;
         mon_q <= `POF_MON_RST;
         o_reg_rdata <= 8'h00;
      end else begin
         fmt_q <= fmt_d;
         hs_q <= hs_d;
         mon_q <= mon_d;
         o_reg_rdata <= rdata_d;
      end
   end

   assign dual = fmt_q[`POF_FMT_DUAL];
   assign par = fmt_q[`POF_FMT_PAR];
   assign swap = fmt_q[`POF_FMT_SWAP];
   assign phase = mon_q[`POF_MON_PHASE_HI:`POF_MON_PHASE_LO];

   // -----------------------------------------------------------------
   // Pixel buffer and pixel-rate enable
   // -----------------------------------------------------------------
   logic fifo_valid, pop, ph_q, ph_d, pix_en;
   pof_word_t word;

   // The pixel rate is half the core rate so a single-mode output clock can make a full period per pixel.
   assign pix_en = ~ph_q;
   assign pop = pix_en && fifo_valid && i_out_ready;

   pof_fifo #(.WIDTH($bits(pof_word_t)), .DEPTH(DEPTH)) u_fifo (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_in_valid(i_pix_valid),
      .i_in_data(i_pix),
      .o_in_ready(o_pix_ready),
      .o_out_valid(fifo_valid),
      .o_out_data(word),
      .i_out_ready(pop)
   );

   // -----------------------------------------------------------------
   // Port routing
   // -----------------------------------------------------------------
   pof_slot_t st_q, st_d, slot;
   pof_pix_t hold_q, hold_d;
   pof_out_t raw_q, raw_d;
   logic pclk_q, pclk_d, to_b;

   always_comb begin
      slot = word.sol ? POF_ST_FIRST : st_q;
      to_b = (slot == POF_ST_SECOND) ^ swap;
      ph_d = ~ph_q;
      st_d = st_q;
      hold_d = hold_q;
      pclk_d = pix_en ? ~pclk_q : pclk_q;
      raw_d = raw_q;
      raw_d.hs = 1'b0;
      raw_d.b_oe = dual;
      // Single mode toggles every core cycle, dual every pixel: a full or half pixel-rate clock.
      raw_d.clk = dual ? pclk_q : ph_q;
      if (pop) begin
         st_d = (slot == POF_ST_FIRST) ? POF_ST_SECOND : POF_ST_FIRST;
         if (!dual) begin
            raw_d.a = word.pix;
         end else if (!par) begin
            if (to_b) begin
               raw_d.b = word.pix;
            end else begin
               raw_d.a = word.pix;
            end
         end else if (slot == POF_ST_FIRST) begin
            hold_d = word.pix;
         end else if (swap) begin
            raw_d.a = word.pix;
            raw_d.b = hold_q;
         end else begin
            raw_d.a = hold_q;
            raw_d.b = word.pix;
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         ph_q <= 1'b0;
         st_q <= POF_ST_FIRST;
         hold_q <= '0;
         pclk_q <= 1'b0;
         raw_q <= '0;
      end else begin
         ph_q <= ph_d;
         st_q <= st_d;
         hold_q <= hold_d;
         pclk_q <= pclk_d;
         raw_q <= raw_d;
      end
   end

   // -----------------------------------------------------------------
   // Line sync and phase delay line
   // -----------------------------------------------------------------
   logic gen_hs;
   pof_out_t stage;
   pof_out_t tap_q [`POF_PHASE_TAPS];
   pof_out_t tap_d [`POF_PHASE_TAPS];
   pof_out_t out_q, out_d;

   pof_hs_gen #(.WBITS(7)) u_hs (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_start(pop && word.sol),
      .i_pix_en(pix_en),
      .i_width(hs_q[`POF_HS_WIDTH_HI:0]),
      .i_pol(hs_q[`POF_HS_POL]),
      .o_hs(gen_hs)
   );

   always_comb begin
      stage = raw_q;
      stage.hs = gen_hs;
      tap_d[0] = stage;
      for (int i = 1; i < `POF_PHASE_TAPS; i++) begin
         tap_d[i] = tap_q[i-1];
      end
      out_d = tap_q[phase];
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         for (int i = 0; i < `POF_PHASE_TAPS; i++) begin
            tap_q[i] <= '0;
         end
         out_q <= '0;
      end else begin
         tap_q <= tap_d;
         out_q <= out_d;
      end
   end

   assign o_port_a = out_q.a;
   assign o_port_b = out_q.b;
   assign o_port_b_oe = out_q.b_oe;
   assign o_data_out_clock = out_q.clk;
   assign o_data_out_clock_n = ~out_q.clk;
   assign o_line_sync_out = out_q.hs;

   // -----------------------------------------------------------------
   // Sync monitor
   // -----------------------------------------------------------------
   // Both pins are asynchronous; the first flop of each pair feeds only the second.
   logic [1:0] hs_sync_q, hs_sync_d, sog_sync_q, sog_sync_d;
   logic [`POF_SYNC_DLY-1:0] hs_dly_q, hs_dly_d;
   logic mon_out_q, mon_out_d;

   always_comb begin
      hs_sync_d = {hs_sync_q[0], i_hsync};
      sog_sync_d = {sog_sync_q[0], i_green_embedded_sync};
      hs_dly_d = {hs_dly_q[`POF_SYNC_DLY-2:0], hs_sync_q[1]};
      mon_out_d = mon_q[`POF_MON_SOG] ? sog_sync_q[1] : hs_dly_q[`POF_SYNC_DLY-1];
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         hs_sync_q <= 2'h0;
         sog_sync_q <= 2'h0;
         hs_dly_q <= '0;
         mon_out_q <= 1'b0;
      end else begin
         hs_sync_q <= hs_sync_d;
         sog_sync_q <= sog_sync_d;
         hs_dly_q <= hs_dly_d;
         mon_out_q <= mon_out_d;
      end
   end

   assign o_sync_slice_monitor_out = mon_out_q;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_reset);

   chk_single_hiz: assert property (!dual |=> !raw_q.b_oe)
      else $error("second port enabled in single mode");
   chk_single_data: assert property (pop && !dual |=> raw_q.a == $past(word.pix))
      else $error("single mode data not on first port");
   chk_first_port: assert property (pop && dual && !par && word.sol && !swap |=> raw_q.a == $past(word.pix))
      else $error("first pixel after sync not on first port");
   chk_swap_route: assert property (pop && dual && !par && word.sol && swap |=> raw_q.b == $past(word.pix))
      else $error("swapped first pixel not on second port");
   chk_par_hold: assert property (pop && dual && par && slot == POF_ST_FIRST |=> $stable(raw_q.a) && $stable(raw_q.b))
      else $error("parallel ports changed on first pixel");
   chk_ileave_second: assert property (pop && dual && !par && !word.sol && st_q == POF_ST_SECOND && !swap
      |=> raw_q.b == $past(word.pix) && $stable(raw_q.a))
      else $error("interleaved second pixel misrouted");
   chk_fixed_latency: assert property (phase == 2'd0 && $past(phase) == 2'd0 |-> out_q == $past(stage, 2))
      else $error("latency at zero phase wrong");
   chk_phase_shift: assert property ((phase == 2'd3)[*5] |-> out_q == $past(stage, 5))
      else $error("phase shift did not move all outputs");
   chk_clk_single: assert property ((!dual)[*3] |-> raw_q.clk != $past(raw_q.clk))
      else $error("single mode clock not at pixel rate");
   chk_clk_dual: assert property (dual ##1 (dual && pix_en) ##1 dual ##1 dual
      |-> raw_q.clk != $past(raw_q.clk, 2) && $past(raw_q.clk) == $past(raw_q.clk, 2))
      else $error("dual mode clock not at half rate");
   chk_hs_start: assert property (pop && word.sol && hs_q[`POF_HS_WIDTH_HI:0] != 7'h00 |=> gen_hs == hs_q[`POF_HS_POL])
      else $error("line sync pulse wrong polarity");
   chk_mon_sog: assert property (mon_q[`POF_MON_SOG] |=> mon_out_q == $past(sog_sync_q[1]))
      else $error("monitor does not carry slicer");
   chk_mon_hs: assert property (!mon_q[`POF_MON_SOG] |=> mon_out_q == $past(hs_dly_q[`POF_SYNC_DLY-1]))
      else $error("monitor does not carry delayed line sync");
   chk_oe_dual: assert property (dual |=> raw_q.b_oe)
      else $error("second port released in dual mode");
   chk_ileave_first: assert property (pop && dual && !par && !word.sol && st_q == POF_ST_FIRST && !swap
      |=> raw_q.a == $past(word.pix) && $stable(raw_q.b))
      else $error("interleaved odd pixel misrouted");
   chk_par_pair: assert property (pop && dual && par && slot == POF_ST_SECOND && !swap
      |=> raw_q.a == $past(hold_q) && raw_q.b == $past(word.pix))
      else $error("parallel pair not presented together");

   cov_dual_par: cover property (pop && dual && par && slot == POF_ST_SECOND);
   cov_swap_ileave: cover property (pop && dual && !par && swap && word.sol);
   cov_phase_max: cover property (phase == 2'd3 && out_q.hs);
   cov_fifo_full: cover property (!o_pix_ready);
endmodule

// >>> testbench/pof_capture_model.sv
// Purpose: Downstream capture logic facing the output formatter.
// Assumes: Successive test pixels differ, so each new value on a port is one output pixel.
// Notes: Stamps count core cycles since reset; the bench compares stamp differences only.
module pof_capture_model import pof_pkg::*; (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset,
   // Formatter outputs
   input wire pof_pix_t i_port_a,
   input wire pof_pix_t i_port_b,
   input wire logic i_port_b_oe,
   input wire logic i_data_out_clock,
   input wire logic i_line_sync_out,
   // Flow control
   input wire logic i_stall,
   output logic o_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [20:0] port_b_pin;
   logic [20:0] last_a, last_b;
   logic last_hs;
   int cyc;
   logic [20:0] qa[$], qb[$];
   int sa[$], sb[$], hs_t[$];
   // A released second port floats, so nothing can be latched from it.
   assign port_b_pin = i_port_b_oe ? i_port_b : 21'bz;
   assign o_ready = !i_stall;
   always @(negedge i_core_clk) begin
      if (i_reset) begin
         cyc = 0;
      end else begin
         cyc++;
      end
   end
   // Single mode latches on the rising output clock, one core cycle after the data moved.
   // Dual mode latches on both edges, since in interleaved mode each edge falls midway between two port updates.
   always @(i_data_out_clock or posedge i_reset) begin
      if (i_reset) begin
         last_a = '0;
         last_b = '0;
         last_hs = 1'b0;
      end else if (i_data_out_clock === 1'b1 || i_port_b_oe === 1'b1) begin
         if (i_port_a !== last_a) begin
            qa.push_back(i_port_a);
            sa.push_back(cyc);
            last_a = i_port_a;
         end
         if (port_b_pin !== 21'bz && port_b_pin !== last_b) begin
            qb.push_back(port_b_pin);
            sb.push_back(cyc);
            last_b = port_b_pin;
         end
         if (i_line_sync_out !== last_hs) begin
            hs_t.push_back(cyc);
            last_hs = i_line_sync_out;
         end
      end
   end
endmodule

// >>> testbench/pof_formatter_tb.sv
// Purpose: Self-checking bench for the output formatter.
// Assumes: Inputs change at the falling clock edge.
// Notes: Output timing is judged from capture stamps of the downstream model.
`include "pof_consts.svh"
`define CHK(nm, exp, got) begin \
   checked++; \
   if ((got) !== (exp)) begin \
      n_errors++; \
      $display("[FAIL] %s exp=%0h got=%0h", nm, exp, got); \
   end \
end
module pof_formatter_tb import pof_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_core_clk = 1'b0;
   logic i_reset, i_reg_wr, i_pix_valid, i_hsync, i_green_embedded_sync, stall, i_out_ready, o_pix_ready;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
   pof_word_t i_pix;
   pof_pix_t o_port_a, o_port_b;
   logic o_port_b_oe, o_data_out_clock, o_data_out_clock_n, o_line_sync_out, o_sync_slice_monitor_out;
   int checked = 0;
   int n_errors = 0;
   int tcyc;

   always #12.5 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk or posedge i_reset) tcyc <= i_reset ? 0 : tcyc + 1;

   pof_formatter dut_u (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_reg_wr(i_reg_wr),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .i_pix_valid(i_pix_valid), .i_pix(i_pix), .o_pix_ready(o_pix_ready), .i_out_ready(i_out_ready),
      .i_hsync(i_hsync), .i_green_embedded_sync(i_green_embedded_sync), .o_port_a(o_port_a),
      .o_port_b(o_port_b), .o_port_b_oe(o_port_b_oe), .o_data_out_clock(o_data_out_clock),
      .o_data_out_clock_n(o_data_out_clock_n), .o_line_sync_out(o_line_sync_out),
      .o_sync_slice_monitor_out(o_sync_slice_monitor_out));
   pof_capture_model cap_u (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_port_a(o_port_a),
      .i_port_b(o_port_b), .i_port_b_oe(o_port_b_oe), .i_data_out_clock(o_data_out_clock),
      .i_line_sync_out(o_line_sync_out),
      .i_stall(stall), .o_ready(i_out_ready));

   // ----------------------------------------------------------------
   // Bus and stream tasks
   // ----------------------------------------------------------------
   function automatic pof_pix_t px(input int k);
      px = {7'(k), 7'(k + 1), 7'(k + 2)};
   endfunction
   function automatic pof_word_t mk(input logic sol, input int k);
      mk = {sol, px(k)};
   endfunction
   task automatic end_of_test();
      $display("checks=%0d errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic do_reset();
      i_reset = 1'b1;
      repeat (8) @(negedge i_core_clk);
      i_reset = 1'b0;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      i_reg_wr = 1'b1;
      i_reg_addr = a;
      i_reg_wdata = d;
      @(negedge i_core_clk);
      i_reg_wr = 1'b0;
      @(negedge i_core_clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      i_reg_addr = a;
      @(negedge i_core_clk);
      `CHK("rdata", exp, o_reg_rdata)
   endtask
   task automatic idle(input int n);
      i_pix_valid = 1'b0;
      repeat (n) @(negedge i_core_clk);
   endtask
   task automatic push(input pof_word_t w);
      int n;
      n = 0;
      i_pix_valid = 1'b1;
      i_pix = w;
      while (o_pix_ready !== 1'b1 && n < 100) begin
         @(negedge i_core_clk);
         n++;
      end
      @(negedge i_core_clk);
   endtask
   task automatic clear();
      cap_u.qa.delete();
      cap_u.qb.delete();
      cap_u.sa.delete();
      cap_u.sb.delete();
      cap_u.hs_t.delete();
   endtask
   task automatic send(input int base, input logic [7:0] fmt);
      wreg(`POF_REG_FMT, fmt);
      idle(10);
      clear();
      for (int i = 0; i < 4; i++) push(mk(i == 0, base + i));
      idle(60);
   endtask
   task automatic toggles(input int exp);
      int n;
      logic p;
      n = 0;
      p = o_data_out_clock;
      repeat (8) begin
         @(negedge i_core_clk);
         n += (o_data_out_clock !== p);
         p = o_data_out_clock;
         `CHK("clk_n", ~o_data_out_clock, o_data_out_clock_n)
      end
      `CHK("clk_toggles", exp, n)
   endtask
   task automatic chk_dual(input int base, input int swap);
      `CHK("a_count", 2, cap_u.qa.size())
      `CHK("b_count", 2, cap_u.qb.size())
      `CHK("b_oe", 1'b1, o_port_b_oe)
      for (int i = 0; i < 2; i++) begin
         `CHK("port_a", px(base + 2 * i + swap), cap_u.qa[i])
         `CHK("port_b", px(base + 2 * i + 1 - swap), cap_u.qb[i])
      end
   endtask
   task automatic mon_pulse(input bit sel, output int d, output int w);
      d = -1;
      w = 0;
      // The unselected input toggles every cycle and must never show.
      for (int i = 0; i < 24; i++) begin
         i_green_embedded_sync = sel ? (i < 8) : i[0];
         i_hsync = sel ? i[0] : (i < 8);
         @(negedge i_core_clk);
         if (o_sync_slice_monitor_out === 1'b1) begin
            w++;
            if (d < 0) d = i + 1;
         end
      end
      i_green_embedded_sync = 1'b0;
      i_hsync = 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      `CHK("oe_rst", 1'b0, o_port_b_oe)
      `CHK("clkn_rst", 1'b1, o_data_out_clock_n)
      rchk(`POF_REG_FMT, `POF_FMT_RST);
      rchk(`POF_REG_HS, `POF_HS_RST);
      rchk(`POF_REG_MON, `POF_MON_RST);
      wreg(`POF_REG_FMT, 8'he0);
      wreg(8'h20, 8'hff);
      rchk(`POF_REG_FMT, 8'he0);
      rchk(8'h20, 8'h00);
   endtask
   task automatic t_single();
      send(16, 8'h00);
      `CHK("a_count", 4, cap_u.qa.size())
      `CHK("b_count", 0, cap_u.qb.size())
      `CHK("b_oe", 1'b0, o_port_b_oe)
      for (int i = 0; i < 4; i++) `CHK("port_a", px(16 + i), cap_u.qa[i])
      `CHK("a_step", 2, cap_u.sa[1] - cap_u.sa[0])
      `CHK("hs_align", cap_u.sa[0], cap_u.hs_t[0])
      toggles(8);
   endtask
   task automatic t_dual();
      send(32, 8'h80);
      chk_dual(32, 0);
      `CHK("b_after_a", 2, cap_u.sb[0] - cap_u.sa[0])
      `CHK("a_step", 4, cap_u.sa[1] - cap_u.sa[0])
      toggles(4);
      send(48, 8'ha0);
      chk_dual(48, 1);
      send(64, 8'hc0);
      chk_dual(64, 0);
      `CHK("par_same", cap_u.sa[0], cap_u.sb[0])
      `CHK("a_step", 4, cap_u.sa[1] - cap_u.sa[0])
   endtask
   task automatic t_fifo();
      int n;
      n = 0;
      wreg(`POF_REG_FMT, 8'h00);
      stall = 1'b1;
      idle(10);
      clear();
      while (o_pix_ready === 1'b1 && n < 40) begin
         i_pix_valid = 1'b1;
         i_pix = mk(n == 0, 80 + n);
         @(negedge i_core_clk);
         n++;
      end
      idle(10);
      `CHK("fill", `POF_FIFO_DEPTH, n)
      `CHK("stalled", 0, cap_u.qa.size())
      stall = 1'b0;
      idle(20);
      stall = 1'b1;
      idle(20);
      stall = 1'b0;
      idle(80);
      for (int i = 0; i < 32; i++) `CHK("drain", px(80 + i), cap_u.qa[i])
      `CHK("ready", 1'b1, o_pix_ready)
   endtask
   task automatic t_monitor();
      int d, w;
      wreg(`POF_REG_MON, 8'h01);
      mon_pulse(1'b1, d, w);
      `CHK("slice_dly", 3, d)
      `CHK("slice_wid", 8, w)
      wreg(`POF_REG_MON, 8'h00);
      idle(10);
      mon_pulse(1'b0, d, w);
      `CHK("hs_dly", 6, d)
      `CHK("hs_wid", 8, w)
   endtask
   task automatic t_phase();
      int lat[2];
      int t;
      for (int p = 0; p < 2; p++) begin
         do_reset();
         wreg(`POF_REG_MON, p ? 8'h06 : 8'h00);
         clear();
         t = tcyc;
         push(mk(1'b1, 8));
         idle(11);
         push(mk(1'b0, 12));
         idle(40);
         lat[p] = cap_u.sa[0] - t;
         `CHK("lat_fixed", 12, cap_u.sa[1] - cap_u.sa[0])
         `CHK("hs_phase", cap_u.sa[0], cap_u.hs_t[0])
      end
      `CHK("phase_shift", 3, lat[1] - lat[0])
   endtask
   task automatic t_sync_width();
      wreg(`POF_REG_HS, 8'h03);
      idle(20);
      `CHK("hs_idle", 1'b1, o_line_sync_out)
      clear();
      push(mk(1'b1, 100));
      idle(30);
      `CHK("hs_low", 6, cap_u.hs_t[1] - cap_u.hs_t[0])
      wreg(`POF_REG_HS, 8'h82);
      idle(20);
      `CHK("hs_idle", 1'b0, o_line_sync_out)
      clear();
      push(mk(1'b1, 104));
      idle(30);
      `CHK("hs_high", 4, cap_u.hs_t[1] - cap_u.hs_t[0])
   endtask

   // ----------------------------------------------------------------
   // Sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      i_reg_wr = 1'b0;
      i_reg_addr = 8'h00;
      i_reg_wdata = 8'h00;
      i_pix_valid = 1'b0;
      i_pix = '0;
      i_hsync = 1'b0;
      i_green_embedded_sync = 1'b0;
      stall = 1'b0;
      do_reset();
      t_regs();
      t_single();
      t_dual();
      t_fifo();
      t_monitor();
      t_phase();
      t_sync_width();
      end_of_test();
   end
   // About 800 cycles are expected; 6,000 cycles, over seven times that, means a hang.
   initial begin
      #(25 * 6000);
      n_errors++;
      end_of_test();
   end
endmodule
